// *** asp_cfg.svh ***
// constants for the alternate pin steering port: offsets, fields, resets, pin locations
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

// register byte offsets; each port owns a block of four words
`define ASP_SEL0_OFS     8'h00
`define ASP_SEL1_OFS     8'h04
`define ASP_PORTA_BASE   8'h10
`define ASP_PORTB_BASE   8'h20
`define ASP_PORTC_BASE   8'h30
// word index inside a port block
`define ASP_LAT_IDX      2'd0
`define ASP_PIN_IDX      2'd1
`define ASP_DIR_IDX      2'd2
`define ASP_ANS_IDX      2'd3

// field positions in selection register 0
`define ASP_RXDT_BIT     7
`define ASP_SDO_BIT      6
`define ASP_SS_BIT       5
`define ASP_TGATE_BIT    3
`define ASP_TXCK_BIT     2
// field positions in selection register 1
`define ASP_SECOND_SERIAL_OUT_BIT     5
`define ASP_SS2_BIT      4
`define ASP_PWMD_BIT     3
`define ASP_PWM2B_BIT    1
`define ASP_SECOND_CAPCOMP_BIT     0

// implemented selection bits per package variant
`define ASP_SEL0_MASK14  8'hec
`define ASP_SEL0_MASK20  8'h8c
`define ASP_SEL1_MASK14  8'h0b
`define ASP_SEL1_MASK20  8'h3b

// reset values
`define ASP_SEL_RST      8'h00
`define ASP_DIR_RST      8'hff
`define ASP_LAT_RST      8'h00
`define ASP_ANS_RST      8'hff

// implemented lines per port, and input-only lines of port a
`define ASP_IMPL_A       8'h3f
`define ASP_IMPL_B       8'hf0
`define ASP_IMPL_C       8'hff
`define ASP_INONLY_A     8'h08

// pin locations as {port, line}; port a = 0, b = 1, c = 2
`define ASP_LOC_A0       5'h00
`define ASP_LOC_A1       5'h01
`define ASP_LOC_A3       5'h03
`define ASP_LOC_A4       5'h04
`define ASP_LOC_A5       5'h05
`define ASP_LOC_B5       5'h0d
`define ASP_LOC_B7       5'h0f
`define ASP_LOC_C0       5'h10
`define ASP_LOC_C1       5'h11
`define ASP_LOC_C2       5'h12
`define ASP_LOC_C3       5'h13
`define ASP_LOC_C4       5'h14
`define ASP_LOC_C5       5'h15
`define ASP_LOC_C6       5'h16
`define ASP_LOC_C7       5'h17

`endif

// *** asp_periph_model.sv ***
// behavioural peripherals and pad environment facing the pin steering port
`timescale 1ns/100ps
`default_nettype none

module asp_periph_model
    import asp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [6:0]  fnOn,
    input  wire logic        fnVal,
    input  wire asp_pins_t   extLevel,
    input  wire asp_pins_t   padOut,
    input  wire asp_pins_t   padOe,
    output asp_periph_out_t  periphOut,
    output asp_pins_t        padIn
);
    logic [20:0] fnVec;

    ////////////////////////////////////////////////////////////////////////////////
    // one function per fnOn bit, msb rxdt down to capcomp2; enabled functions drive
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            fnVec[3*i +: 3] = {fnOn[i], fnOn[i], fnVal};
        end
    end

    // registered so the port sees peripheral changes like a real clocked unit
    always_ff @(posedge mclk) begin
        periphOut <= asp_periph_out_t'(fnVec);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // a driven pad reads back its own value; otherwise the outside world sets it
    assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule
`default_nettype wire

// *** asp_pin_steer.sv ***
// alternate pin steering and general purpose port logic behind an ahb-lite slave
// Operation
// - writing the latch register equals writing the pin-value register
// - latch register reads latches; pin-value register reads sampled pin levels
// - an enabled peripheral takes its pin away from general purpose use
// - analog select bit disables the pin's digital input buffer
// - writing selection bits never changes any direction register
// - peripheral overrides land only on the selected pin; other pin untouched
// - sel0 bit 7 steers receive/sync data per package variant
// - sel0 bit 6 steers serial out; fixed and read zero on 20-pin
// - sel0 bit 5 steers first slave select; fixed and zero on 20-pin
// - sel0 bit 3 steers timer gate between port a lines 4 and 3
// - sel0 bit 2 steers transmit/sync clock per package variant
// - unimplemented selection bits ignore writes and read zero
// - sel1 bit 5 steers second serial out, 20-pin only
// - sel1 bit 4 steers second slave select, 20-pin only
// - sel1 bit 3 steers pwm output d between port c lines 2 and 0
// - sel1 bit 1 steers second pwm output b to c2 or a4
// - sel1 bit 0 steers second capture/compare to c3 or a5
// - several outputs on one pin: highest priority peripheral wins
// - direction 1 disables driver; direction 0 drives latch onto pin
// - analog pins read zero digitally; digital output still works
`timescale 1ns/100ps
`default_nettype none
`include "asp_cfg.svh"

module asp_pin_steer
    import asp_pkg::*;
#(
    parameter bit PIN20  = 1'b0,  // 0: 14-pin variant, 1: 20-pin variant
    parameter int ADDR_W = 12
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // package pins
    input  wire asp_pins_t         padIn,
    output asp_pins_t              padOut,
    output asp_pins_t              padOe,
    // peripherals
    input  wire asp_periph_out_t   periphOut,
    output asp_periph_in_t         periphIn
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]  sel0_q;
    logic [7:0]  sel1_q;
    asp_pins_t   dir_q;
    asp_pins_t   lat_q;
    asp_pins_t   ans_q;
    asp_pins_t   pin_q;
    asp_pins_t   padOut_q;
    asp_pins_t   padOe_q;
    asp_periph_in_t periphIn_q;
    logic [31:0] hrdata_q;
    logic        hreadyout_q;
    logic        hresp_q;
    logic        wrPend_q;
    logic [7:0]  wrAddr_q;

    logic [7:0]  sel0Mask;
    logic [7:0]  sel1Mask;
    asp_pins_t   implMask;
    asp_pins_t   digIn;
    asp_fn_t     ov [3][8];
    asp_loc_t    locRxdt;
    asp_loc_t    locTxck;
    asp_loc_t    locSdo;
    asp_loc_t    locSs1;
    asp_loc_t    locTgate;
    asp_loc_t    locSdo2;
    asp_loc_t    locSs2;
    asp_loc_t    locPwmD;
    asp_loc_t    locPwm2B;
    asp_loc_t    locCcp2;
    logic        addrTaken;
    logic        wrSel0;
    logic        wrSel1;
    logic [2:0]  wrLat;
    logic [2:0]  wrDir;
    logic [2:0]  wrAns;
    logic [31:0] rdData;
    logic [1:0]  rdPort;

    ////////////////////////////////////////////////////////////////////////////
    // variant masks; port b exists only on the 20-pin part
    assign sel0Mask    = PIN20 ? `ASP_SEL0_MASK20 : `ASP_SEL0_MASK14;
    assign sel1Mask    = PIN20 ? `ASP_SEL1_MASK20 : `ASP_SEL1_MASK14;
    assign implMask[0] = `ASP_IMPL_A;
    assign implMask[1] = PIN20 ? `ASP_IMPL_B : 8'h00;
    assign implMask[2] = `ASP_IMPL_C;

    // analog pins present zero to every digital reader
    assign digIn = pin_q & ~ans_q & implMask;

    ////////////////////////////////////////////////////////////////////////////
    // pin location of each steerable function
    always_comb begin
        if (PIN20) begin
            locRxdt = sel0_q[`ASP_RXDT_BIT] ? `ASP_LOC_C5 : `ASP_LOC_B5;
            locTxck = sel0_q[`ASP_TXCK_BIT] ? `ASP_LOC_C4 : `ASP_LOC_B7;
            locSdo  = `ASP_LOC_C7;
            locSs1  = `ASP_LOC_C6;
        end else begin
            locRxdt = sel0_q[`ASP_RXDT_BIT] ? `ASP_LOC_A1 : `ASP_LOC_C5;
            locTxck = sel0_q[`ASP_TXCK_BIT] ? `ASP_LOC_A0 : `ASP_LOC_C4;
            locSdo  = sel0_q[`ASP_SDO_BIT] ? `ASP_LOC_A4 : `ASP_LOC_C2;
            locSs1  = sel0_q[`ASP_SS_BIT] ? `ASP_LOC_A3 : `ASP_LOC_C3;
        end
        locTgate = sel0_q[`ASP_TGATE_BIT] ? `ASP_LOC_A3 : `ASP_LOC_A4;
        locSdo2  = sel1_q[`ASP_SECOND_SERIAL_OUT_BIT] ? `ASP_LOC_A5 : `ASP_LOC_C1;
        locSs2   = sel1_q[`ASP_SS2_BIT] ? `ASP_LOC_A4 : `ASP_LOC_C0;
        locPwmD  = sel1_q[`ASP_PWMD_BIT] ? `ASP_LOC_C0 : `ASP_LOC_C2;
        locPwm2B = sel1_q[`ASP_PWM2B_BIT] ? `ASP_LOC_A4 : `ASP_LOC_C2;
        locCcp2  = sel1_q[`ASP_SECOND_CAPCOMP_BIT] ? `ASP_LOC_A5 : `ASP_LOC_C3;
    end

    ////////////////////////////////////////////////////////////////////////////
    // override map: lowest priority written first so the highest lands last
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 8; i++) begin
                ov[p][i] = '0;
            end
        end
        if (periphOut.txck.en) ov[locTxck[4:3]][locTxck[2:0]] = periphOut.txck;
        if (periphOut.rxdt.en) ov[locRxdt[4:3]][locRxdt[2:0]] = periphOut.rxdt;
        if (periphOut.capcomp2.en) ov[locCcp2[4:3]][locCcp2[2:0]] = periphOut.capcomp2;
        if (periphOut.pwm2B.en) ov[locPwm2B[4:3]][locPwm2B[2:0]] = periphOut.pwm2B;
        if (periphOut.pwmD.en) ov[locPwmD[4:3]][locPwmD[2:0]] = periphOut.pwmD;
        // second serial module only exists on the 20-pin part
        if (PIN20 && periphOut.second_serial_out.en) ov[locSdo2[4:3]][locSdo2[2:0]] = periphOut.second_serial_out;
        if (periphOut.sdo.en) ov[locSdo[4:3]][locSdo[2:0]] = periphOut.sdo;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad drivers, one per line
    for (genvar p = 0; p < 3; p++) begin : g_port
        for (genvar i = 0; i < 8; i++) begin : g_line
            always_ff @(posedge mclk) begin
                if (rst) begin
                    padOut_q[p][i] <= 1'b0;
                    padOe_q[p][i]  <= 1'b0;
                end else if (!implMask[p][i]) begin
                    padOut_q[p][i] <= 1'b0;
                    padOe_q[p][i]  <= 1'b0;
                end else if (ov[p][i].en) begin
                    // owning peripheral decides value and driver
                    padOut_q[p][i] <= ov[p][i].out;
                    padOe_q[p][i]  <= ov[p][i].oe;
                end else begin
                    padOut_q[p][i] <= lat_q[p][i];
                    padOe_q[p][i]  <= ~dir_q[p][i];
                end
            end
        end
    end

    // pins are taken as synchronous; one sample stage feeds all readers
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_q <= '0;
        end else begin
            pin_q <= padIn;
        end
    end

    // inputs handed to peripherals from the selected pin only
    always_ff @(posedge mclk) begin
        if (rst) begin
            periphIn_q <= '0;
        end else begin
            periphIn_q.receiveSyncData   <= digIn[locRxdt[4:3]][locRxdt[2:0]];
            periphIn_q.transmitSyncClock <= digIn[locTxck[4:3]][locTxck[2:0]];
            periphIn_q.timerGateInput    <= digIn[locTgate[4:3]][locTgate[2:0]];
            periphIn_q.firstSlaveSelect  <= digIn[locSs1[4:3]][locSs1[2:0]];
            // absent second module sees an idle-high select
            periphIn_q.secondSlaveSelect <= PIN20 ? digIn[locSs2[4:3]][locSs2[2:0]] : 1'b1;
            periphIn_q.secondCapcomp     <= digIn[locCcp2[4:3]][locCcp2[2:0]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite address phase capture; zero wait states, always okay
    assign addrTaken = hsel & htrans[1] & hready;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else begin
            wrPend_q <= addrTaken & hwrite;
            wrAddr_q <= addrTaken ? haddr[7:0] : wrAddr_q;
        end
    end

    // write decode in the data phase; only address bits 7:0 are decoded, upper bits are ignored
    always_comb begin
        wrSel0 = 1'b0;
        wrSel1 = 1'b0;
        wrLat  = 3'b000;
        wrDir  = 3'b000;
        wrAns  = 3'b000;
        if (wrPend_q && wrAddr_q[1:0] == 2'b00) begin
            wrSel0 = wrAddr_q == `ASP_SEL0_OFS;
            wrSel1 = wrAddr_q == `ASP_SEL1_OFS;
            for (int p = 0; p < 3; p++) begin
                if (wrAddr_q[7:4] == 4'(p + 1)) begin
                    // latch and pin-value addresses land in the same latch
                    wrLat[p] = wrAddr_q[3:2] == `ASP_LAT_IDX
                            || wrAddr_q[3:2] == `ASP_PIN_IDX;
                    wrDir[p] = wrAddr_q[3:2] == `ASP_DIR_IDX;
                    wrAns[p] = wrAddr_q[3:2] == `ASP_ANS_IDX;
                end
            end
        end
    end

    // selection registers; unimplemented bits never store
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel0_q <= `ASP_SEL_RST;
            sel1_q <= `ASP_SEL_RST;
        end else begin
            if (wrSel0) sel0_q <= hwdata[7:0] & sel0Mask;
            if (wrSel1) sel1_q <= hwdata[7:0] & sel1Mask;
        end
    end

    // port registers; direction only moves on its own address
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int p = 0; p < 3; p++) begin
                dir_q[p] <= `ASP_DIR_RST;
                lat_q[p] <= `ASP_LAT_RST;
                ans_q[p] <= `ASP_ANS_RST & implMask[p];
            end
        end else begin
            for (int p = 0; p < 3; p++) begin
                // the input-only line keeps its direction bit set
                if (wrDir[p]) dir_q[p] <= hwdata[7:0] | ~implMask[p]
                        | (p == 0 ? `ASP_INONLY_A : 8'h00);
                if (wrLat[p]) lat_q[p] <= hwdata[7:0] & implMask[p]
                        & ~(p == 0 ? `ASP_INONLY_A : 8'h00);
                if (wrAns[p]) ans_q[p] <= hwdata[7:0] & implMask[p];
            end
        end
    end

    // read mux on the address phase; unmapped reads return zero
    always_comb begin
        rdData = 32'h0000_0000;
        rdPort = haddr[5:4] - 2'd1;
        if (haddr[1:0] == 2'b00 && haddr[ADDR_W-1:8] == '0) begin
            if (haddr[7:0] == `ASP_SEL0_OFS) begin
                rdData[7:0] = sel0_q;
            end else if (haddr[7:0] == `ASP_SEL1_OFS) begin
                rdData[7:0] = sel1_q;
            end else if (haddr[7:6] == 2'b00 && haddr[5:4] != 2'b00) begin
                unique case (haddr[3:2])
                    `ASP_LAT_IDX: rdData[7:0] = lat_q[rdPort];
                    `ASP_PIN_IDX: rdData[7:0] = digIn[rdPort];
                    `ASP_DIR_IDX: rdData[7:0] = dir_q[rdPort] & implMask[rdPort];
                    `ASP_ANS_IDX: rdData[7:0] = ans_q[rdPort];
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            hrdata_q    <= (addrTaken && !hwrite) ? rdData : 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;
    assign padOut    = padOut_q;
    assign padOe     = padOe_q;
    assign periphIn  = periphIn_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    pin_write_lat_a: assert property (@(posedge mclk) disable iff (rst)
        wrPend_q && wrAddr_q == `ASP_PORTC_BASE + 8'h04 |=> lat_q[2] == $past(hwdata[7:0]))
        else $error("pin-value write did not reach latch");

    lat_readback_a: assert property (@(posedge mclk) disable iff (rst)
        addrTaken && !hwrite && haddr == ADDR_W'(`ASP_PORTC_BASE) |=> hrdata == {24'h0, $past(lat_q[2])})
        else $error("latch readback wrong");

    analog_zero_a: assert property (@(posedge mclk) disable iff (rst)
        addrTaken && !hwrite && haddr == ADDR_W'(`ASP_PORTA_BASE + 8'h04)
        |=> (hrdata[7:0] & $past(ans_q[0])) == 8'h00)
        else $error("analog pin read non-zero");

    sel_keeps_dir_a: assert property (@(posedge mclk) disable iff (rst)
        wrSel0 || wrSel1 |=> $stable(dir_q))
        else $error("selection write moved direction");

    unimpl_zero_a: assert property (@(posedge mclk) disable iff (rst)
        (sel0_q & ~sel0Mask) == 8'h00 && (sel1_q & ~sel1Mask) == 8'h00)
        else $error("unimplemented selection bit set");

    sdo_priority_a: assert property (@(posedge mclk) disable iff (rst)
        !PIN20 && sel0_q[`ASP_SDO_BIT] && sel1_q[`ASP_PWM2B_BIT]
        && periphOut.sdo.en && periphOut.pwm2B.en
        |=> padOut[0][4] == $past(periphOut.sdo.out))
        else $error("lower priority output won port a line 4");

    input_only_a: assert property (@(posedge mclk) disable iff (rst)
        !padOe[0][3] ##1 !padOe[0][3])
        else $error("input-only line driven");

    dir_drive_a: assert property (@(posedge mclk) disable iff (rst)
        !ov[2][5].en && !dir_q[2][5] |=> padOe[2][5] && padOut[2][5] == $past(lat_q[2][5]))
        else $error("output direction did not drive latch");

    tgate_route_a: assert property (@(posedge mclk) disable iff (rst)
        !sel0_q[`ASP_TGATE_BIT] |=> periphIn.timerGateInput == $past(digIn[0][4]))
        else $error("timer gate not from port a line 4");

endmodule
`default_nettype wire

// *** asp_pkg.sv ***
// types shared by the alternate pin steering port
package asp_pkg;

    // one peripheral function's claim on a pin: owns it, drives it, with value
    typedef struct packed {
        logic en;
        logic oe;
        logic out;
    } asp_fn_t;

    // everything the peripherals offer towards the pins
    typedef struct packed {
        asp_fn_t rxdt;
        asp_fn_t txck;
        asp_fn_t sdo;
        asp_fn_t second_serial_out;
        asp_fn_t pwmD;
        asp_fn_t pwm2B;
        asp_fn_t capcomp2;
    } asp_periph_out_t;

    // pin levels handed back to the peripherals
    typedef struct packed {
        logic receiveSyncData;
        logic transmitSyncClock;
        logic timerGateInput;
        logic firstSlaveSelect;
        logic secondSlaveSelect;
        logic secondCapcomp;
    } asp_periph_in_t;

    // three ports of eight lines: a = 0, b = 1, c = 2
    typedef logic [2:0][7:0] asp_pins_t;

    // pin location {port, line}
    typedef logic [4:0] asp_loc_t;

endpackage

// *** asp_tb.sv ***
// self-checking testbench for the alternate pin steering port, 14-pin variant
`timescale 1ns/100ps
`default_nettype none
`include "asp_cfg.svh"

module tb
    import asp_pkg::*;
;
    typedef struct packed {
        logic       isOut;
        logic [7:0] selAddr;
        logic [7:0] selByte;
        logic [2:0] idx;
        logic [4:0] loc;
        logic [4:0] alt;
    } asp_row_t;

    localparam logic [7:0] S0    = `ASP_SEL0_OFS;
    localparam logic [7:0] S1    = `ASP_SEL1_OFS;
    localparam logic [7:0] C_LAT = `ASP_PORTC_BASE;
    localparam logic [7:0] C_PIN = `ASP_PORTC_BASE + 8'h04;
    localparam logic [7:0] C_DIR = `ASP_PORTC_BASE + 8'h08;
    localparam logic [7:0] C_ANS = `ASP_PORTC_BASE + 8'h0c;
    localparam logic [7:0] A_LAT = `ASP_PORTA_BASE;
    localparam logic [7:0] A_DIR = `ASP_PORTA_BASE + 8'h08;
    localparam logic [7:0] A_ANS = `ASP_PORTA_BASE + 8'h0c;

    logic              mclk;
    logic              rst;
    logic              hsel;
    logic [11:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [31:0]       hwdata;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    asp_pins_t         padIn;
    asp_pins_t         padOut;
    asp_pins_t         padOe;
    asp_pins_t         extLevel;
    asp_periph_out_t   periphOut;
    asp_periph_in_t    periphIn;
    logic [6:0]        fnOn;
    int                mismatches;
    int                checksDone;
    asp_row_t          r;
    logic [2:0][7:0]   regRows [10];
    asp_row_t          rows [22];

    ////////////////////////////////////////////////////////////////////////////////
    // device, its peripherals and the pad world
    asp_pin_steer #(.PIN20(1'b0), .ADDR_W(12)) asp_pin_steer_i (
        .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .periphOut(periphOut), .periphIn(periphIn)
    );
    asp_periph_model asp_periph_model_i (
        .mclk(mclk), .fnOn(fnOn), .fnVal(1'b1), .extLevel(extLevel),
        .padOut(padOut), .padOe(padOe), .periphOut(periphOut), .padIn(padIn)
    );

    // free-running 100 MHz clock
    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single ahb-lite transfer; waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {4'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? wd : 32'h0;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] unused;
        bus(1'b1, a, {24'h0, d}, unused);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        check(rd, {24'h0, exp});
        check({31'h0, hresp}, 32'h0);
    endtask

    // pads lag registers and peripherals by a couple of edges; step off the edge
    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask

    function automatic asp_pins_t onehot(input logic [4:0] loc);
        asp_pins_t p;
        p = '0;
        p[loc[4:3]][loc[2:0]] = 1'b1;
        return p;
    endfunction

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        finish_test();
    end

    initial begin
        regRows = '{{S0, 8'hff, `ASP_SEL0_MASK14}, {S1, 8'hff, `ASP_SEL1_MASK14},
                    {S0, 8'h00, 8'h00}, {S1, 8'h00, 8'h00}, {C_LAT, 8'ha5, 8'ha5},
                    {A_DIR, 8'h00, `ASP_INONLY_A}, {C_ANS, 8'h00, 8'h00},
                    {A_LAT, 8'hff, `ASP_IMPL_A & ~`ASP_INONLY_A},
                    {8'h80, 8'hff, 8'h00}, {A_ANS, 8'h00, 8'h00}};
        // output rows steer a peripheral output, input rows a pin back inward
        rows = '{{1'b1, S0, 8'h00, 3'd5, `ASP_LOC_C4, `ASP_LOC_A0},
                 {1'b1, S0, 8'h04, 3'd5, `ASP_LOC_A0, `ASP_LOC_C4},
                 {1'b1, S0, 8'h00, 3'd6, `ASP_LOC_C5, `ASP_LOC_A1},
                 {1'b1, S0, 8'h80, 3'd6, `ASP_LOC_A1, `ASP_LOC_C5},
                 {1'b1, S0, 8'h00, 3'd4, `ASP_LOC_C2, `ASP_LOC_A4},
                 {1'b1, S0, 8'h40, 3'd4, `ASP_LOC_A4, `ASP_LOC_C2},
                 {1'b1, S1, 8'h00, 3'd2, `ASP_LOC_C2, `ASP_LOC_C0},
                 {1'b1, S1, 8'h08, 3'd2, `ASP_LOC_C0, `ASP_LOC_C2},
                 {1'b1, S1, 8'h00, 3'd1, `ASP_LOC_C2, `ASP_LOC_A4},
                 {1'b1, S1, 8'h02, 3'd1, `ASP_LOC_A4, `ASP_LOC_C2},
                 {1'b1, S1, 8'h00, 3'd0, `ASP_LOC_C3, `ASP_LOC_A5},
                 {1'b1, S1, 8'h01, 3'd0, `ASP_LOC_A5, `ASP_LOC_C3},
                 {1'b0, S0, 8'h00, 3'd5, `ASP_LOC_C5, `ASP_LOC_A1},
                 {1'b0, S0, 8'h80, 3'd5, `ASP_LOC_A1, `ASP_LOC_C5},
                 {1'b0, S0, 8'h00, 3'd4, `ASP_LOC_C4, `ASP_LOC_A0},
                 {1'b0, S0, 8'h04, 3'd4, `ASP_LOC_A0, `ASP_LOC_C4},
                 {1'b0, S0, 8'h00, 3'd3, `ASP_LOC_A4, `ASP_LOC_A3},
                 {1'b0, S0, 8'h08, 3'd3, `ASP_LOC_A3, `ASP_LOC_A4},
                 {1'b0, S0, 8'h00, 3'd2, `ASP_LOC_C3, `ASP_LOC_A3},
                 {1'b0, S0, 8'h20, 3'd2, `ASP_LOC_A3, `ASP_LOC_C3},
                 {1'b0, S1, 8'h00, 3'd0, `ASP_LOC_C3, `ASP_LOC_A5},
                 {1'b0, S1, 8'h01, 3'd0, `ASP_LOC_A5, `ASP_LOC_C3}};
        mclk = 1'b0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = '0;
        extLevel = '0;
        fnOn = '0;
        mismatches = 0;
        checksDone = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        // register access kinds, masks and the unmapped hole
        foreach (regRows[i]) begin
            wr(regRows[i][2], regRows[i][1]);
            rdchk(regRows[i][2], regRows[i][0]);
        end
        $display("register table done");
        wr(C_DIR, 8'h00);
        wr(C_ANS, 8'h00);
        // clear latches so an unselected driven pin reads low
        wr(A_LAT, 8'h00);
        wr(C_LAT, 8'h00);
        foreach (rows[i]) begin
            r = rows[i];
            wr(r.selAddr, r.selByte);
            if (r.isOut) begin
                wr(A_DIR, 8'h00);
                wr(C_DIR, 8'h00);
                fnOn <= 7'h01 << r.idx;
                settle();
                check({31'h0, padOut[r.loc[4:3]][r.loc[2:0]]}, 32'h1);
                check({31'h0, padOe[r.loc[4:3]][r.loc[2:0]]}, 32'h1);
                check({31'h0, padOut[r.alt[4:3]][r.alt[2:0]]}, 32'h0);
            end else begin
                wr(A_DIR, 8'hff);
                wr(C_DIR, 8'hff);
                fnOn <= '0;
                extLevel <= onehot(r.loc);
                settle();
                check({31'h0, periphIn[r.idx]}, 32'h1);
                extLevel <= onehot(r.alt);
                settle();
                check({31'h0, periphIn[r.idx]}, 32'h0);
            end
        end
        $display("steering table done");
        // serial out and second pwm b both claim port a line 4
        wr(S0, 8'h40);
        wr(S1, 8'h02);
        wr(A_DIR, 8'h00);
        fnOn <= 7'h12;
        settle();
        check({31'h0, padOut[0][4]}, 32'h1);
        check({31'h0, padOe[0][4]}, 32'h1);
        wr(S1, 8'h00);
        // latch, pin readback, direction and analog select on port c
        fnOn <= '0;
        extLevel <= '0;
        wr(C_DIR, 8'h00);
        wr(S0, 8'hff);
        rdchk(C_DIR, 8'h00);
        wr(C_PIN, 8'h3c);
        rdchk(C_LAT, 8'h3c);
        wr(C_ANS, 8'hff);
        settle();
        check({24'h0, padOut[2]}, 32'h3c);
        check({24'h0, padOe[2]}, 32'hff);
        rdchk(C_PIN, 8'h00);
        wr(C_ANS, 8'h00);
        settle();
        rdchk(C_PIN, 8'h3c);
        wr(C_DIR, 8'hff);
        settle();
        check({24'h0, padOe[2]}, 32'h0);
        $display("port behaviour done");
        // reset in mid-run returns every register to its reset value
        rst <= 1'b1;
        settle();
        check({8'h0, padOe}, 32'h0);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        rdchk(S0, `ASP_SEL_RST);
        rdchk(S1, `ASP_SEL_RST);
        rdchk(C_DIR, `ASP_DIR_RST);
        rdchk(C_LAT, `ASP_LAT_RST);
        rdchk(C_ANS, `ASP_ANS_RST);
        rdchk(A_DIR, `ASP_IMPL_A);
        rdchk(`ASP_PORTA_BASE + 8'h04, 8'h00);
        $display("reset test done");
        finish_test();
    end
endmodule
`default_nettype wire
